// ### hdl/sbs_pkg.sv
// Shared constants and types of the start-up sequencer.
// Assumes a 100 MHz CPU clock and a sampled system bus clock pin.
package sbs_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SBS_WORD_W = 8;
    localparam int SBS_CNT_W = 23;
    localparam int SBS_DIV_W = 7;

    // ------------------------------------------------------------
    // Timing, in system cycles
    // ------------------------------------------------------------
    localparam logic [SBS_CNT_W-1:0] SBS_FIRST_EVENT = 23'h000007;
    localparam int SBS_BUILT_IN_SELF_TEST_SYS_R4 = 28570;
    localparam int SBS_BUILT_IN_SELF_TEST_SYS_R15 = 15750;
    localparam int SBS_LOAD_SYS_R4 = 4209362;
    localparam int SBS_LOAD_SYS_R15 = 1122497;
    localparam logic [3:0] SBS_RATIO_HIGH = 4'hF;

    // ------------------------------------------------------------
    // Timing, in CPU cycles
    // ------------------------------------------------------------
    localparam int SBS_CPU_PERIOD_NS = 10;
    localparam int SBS_SROM_BIT_CPU = 126;
    localparam logic [SBS_DIV_W-1:0] SBS_SROM_HALF_LAST =
        SBS_DIV_W'(SBS_SROM_BIT_CPU / 2 - 1);
    localparam logic [2:0] SBS_BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_ST_HOLD,
        SBS_ST_SELFTEST,
        SBS_ST_LOAD,
        SBS_ST_RUN
    } sbs_state_type;

    typedef struct packed {
        logic [SBS_WORD_W-1:0] data;
    } sbs_word_type;

    typedef struct packed {
        logic gen_reset;
        logic duty_eq_en;
        logic normal_mode;
    } sbs_clkmode_type;

    typedef struct packed {
        logic head_v;
        logic tail_v;
        sbs_word_type head;
        sbs_word_type tail;
    } sbs_buf_type;

    typedef struct packed {
        logic ext_rst_n_m;
        logic ext_rst_n_s;
        logic pres_n_m;
        logic pres_n_s;
        logic sysclk_m;
        logic sysclk_s;
        logic sysclk_p;
        logic [1:0] mode_m;
        logic [1:0] mode_s;
        logic data_m;
        logic data_s;
        logic [3:0] ratio_m;
        logic [3:0] ratio_s;
        sbs_state_type state;
        logic [SBS_CNT_W-1:0] cnt;
        logic first_event;
        logic [SBS_DIV_W-1:0] div;
        logic srom_clk;
        logic [2:0] bit_cnt;
        logic [SBS_WORD_W-1:0] shift;
        logic push_v;
        sbs_word_type push_word;
        logic core_rst;
        logic selftest_busy;
        logic load_busy;
        sbs_clkmode_type mode_out;
    } sbs_regs_type;

    localparam sbs_regs_type SBS_REGS_RST = '{
        core_rst: 1'b1,
        state: SBS_ST_HOLD,
        default: '0
    };

endpackage

// ### hdl/sbs_seq.sv
// Start-up sequencer: self test, serial boot ROM load, clock modes.
// Assumes clk_i is the CPU clock; all pins arrive asynchronously.
`timescale 1ns/1ps
module sbs_seq #(
    parameter int BUILT_IN_SELF_TEST_SYS_R4 = sbs_pkg::SBS_BUILT_IN_SELF_TEST_SYS_R4,
    parameter int BUILT_IN_SELF_TEST_SYS_R15 = sbs_pkg::SBS_BUILT_IN_SELF_TEST_SYS_R15,
    parameter int LOAD_SYS_R4 = sbs_pkg::SBS_LOAD_SYS_R4,
    parameter int LOAD_SYS_R15 = sbs_pkg::SBS_LOAD_SYS_R15
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Board pins
    input wire logic sys_reset_n_i,
    input wire logic sys_clk_i,
    input wire logic [1:0] clk_mode_i,
    input wire logic [3:0] clk_ratio_i,
    input wire logic srom_present_n_i,
    // Serial boot ROM
    output logic srom_clk_o,
    input wire logic srom_data_i,
    // Loaded words
    output logic word_valid_o,
    output sbs_pkg::sbs_word_type word_o,
    input wire logic word_ready_i,
    // Sequencer status
    output logic core_reset_o,
    output logic selftest_busy_o,
    output logic selftest_mark_o,
    output logic load_busy_o,
    output sbs_pkg::sbs_clkmode_type clk_mode_o
);

    sbs_pkg::sbs_regs_type r_q;
    sbs_pkg::sbs_regs_type r_d;
    logic buf_in_ready;

    // ------------------------------------------------------------
    // Ratio-dependent end counts
    // ------------------------------------------------------------
    logic ratio_high;
    logic [sbs_pkg::SBS_CNT_W-1:0] built_in_self_test_last;
    logic [sbs_pkg::SBS_CNT_W-1:0] load_last;

    assign ratio_high = (r_q.ratio_s == sbs_pkg::SBS_RATIO_HIGH);

    always_comb begin
        if (ratio_high) begin
            built_in_self_test_last = sbs_pkg::SBS_CNT_W'(BUILT_IN_SELF_TEST_SYS_R15);
            load_last = sbs_pkg::SBS_CNT_W'(LOAD_SYS_R15);
        end else begin
            built_in_self_test_last = sbs_pkg::SBS_CNT_W'(BUILT_IN_SELF_TEST_SYS_R4);
            load_last = sbs_pkg::SBS_CNT_W'(LOAD_SYS_R4);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic sys_rise;
        logic stall;
        logic [sbs_pkg::SBS_CNT_W-1:0] cnt_inc;
        sys_rise = 1'b0;
        stall = 1'b0;
        cnt_inc = '0;
        r_d = r_q;

        // Pin synchronizers
        r_d.ext_rst_n_m = sys_reset_n_i;
        r_d.ext_rst_n_s = r_q.ext_rst_n_m;
        r_d.pres_n_m = srom_present_n_i;
        r_d.pres_n_s = r_q.pres_n_m;
        r_d.sysclk_m = sys_clk_i;
        r_d.sysclk_s = r_q.sysclk_m;
        r_d.sysclk_p = r_q.sysclk_s;
        r_d.mode_m = clk_mode_i;
        r_d.mode_s = r_q.mode_m;
        r_d.data_m = srom_data_i;
        r_d.data_s = r_q.data_m;
        r_d.ratio_m = clk_ratio_i;
        r_d.ratio_s = r_q.ratio_m;

        sys_rise = r_q.sysclk_s & ~r_q.sysclk_p;
        cnt_inc = r_q.cnt + 1'b1;
        r_d.first_event = 1'b0;

        // Clock mode decode
        r_d.mode_out.normal_mode = ~r_q.mode_s[1];
        r_d.mode_out.gen_reset = r_q.mode_s[1];
        r_d.mode_out.duty_eq_en = r_q.mode_s[0];

        // Word hand-off to the buffer
        if (r_q.push_v && buf_in_ready) begin
            r_d.push_v = 1'b0;
        end
        stall = r_q.push_v & ~buf_in_ready;

        case (r_q.state)
            sbs_pkg::SBS_ST_HOLD: begin
                r_d.core_rst = 1'b1;
                r_d.cnt = '0;
                r_d.srom_clk = 1'b0;
                if (r_q.ext_rst_n_s) begin
                    r_d.state = sbs_pkg::SBS_ST_SELFTEST;
                end
            end
            sbs_pkg::SBS_ST_SELFTEST: begin
                r_d.core_rst = 1'b1;
                if (sys_rise) begin
                    r_d.cnt = cnt_inc;
                    if (cnt_inc == sbs_pkg::SBS_FIRST_EVENT) begin
                        r_d.first_event = 1'b1;
                    end
                    if (cnt_inc == built_in_self_test_last) begin
                        r_d.cnt = '0;
                        if (r_q.pres_n_s) begin
                            r_d.state = sbs_pkg::SBS_ST_RUN;
                            r_d.core_rst = 1'b0;
                        end else begin
                            r_d.state = sbs_pkg::SBS_ST_LOAD;
                            r_d.div = '0;
                            r_d.bit_cnt = '0;
                            r_d.srom_clk = 1'b0;
                        end
                    end
                end
            end
            sbs_pkg::SBS_ST_LOAD: begin
                r_d.core_rst = 1'b1;
                if (!stall) begin
                    if (r_q.div == sbs_pkg::SBS_SROM_HALF_LAST) begin
                        r_d.div = '0;
                        r_d.srom_clk = ~r_q.srom_clk;
                        if (!r_q.srom_clk) begin
                            r_d.shift = {r_q.data_s,
                                r_q.shift[sbs_pkg::SBS_WORD_W-1:1]};
                            r_d.bit_cnt = r_q.bit_cnt + 1'b1;
                            if (r_q.bit_cnt == sbs_pkg::SBS_BIT_LAST) begin
                                r_d.push_v = 1'b1;
                                r_d.push_word.data = {r_q.data_s,
                                    r_q.shift[sbs_pkg::SBS_WORD_W-1:1]};
                            end
                        end
                    end else begin
                        r_d.div = r_q.div + 1'b1;
                    end
                end
                if (sys_rise) begin
                    r_d.cnt = cnt_inc;
                    if (cnt_inc == load_last) begin
                        r_d.state = sbs_pkg::SBS_ST_RUN;
                        r_d.core_rst = 1'b0;
                        r_d.srom_clk = 1'b0;
                        r_d.cnt = '0;
                    end
                end
            end
            sbs_pkg::SBS_ST_RUN: begin
                r_d.core_rst = 1'b0;
                r_d.srom_clk = 1'b0;
            end
            default: begin
                r_d.state = sbs_pkg::SBS_ST_HOLD;
                r_d.core_rst = 1'b1;
            end
        endcase

        // External reset pulls the sequence back at any time
        if (!r_q.ext_rst_n_s) begin
            r_d.state = sbs_pkg::SBS_ST_HOLD;
            r_d.core_rst = 1'b1;
            r_d.srom_clk = 1'b0;
            r_d.cnt = '0;
        end

        r_d.selftest_busy = (r_d.state == sbs_pkg::SBS_ST_SELFTEST);
        r_d.load_busy = (r_d.state == sbs_pkg::SBS_ST_LOAD);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= sbs_pkg::SBS_REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------
    sbs_skid_buf u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(r_q.push_v),
        .in_word_i(r_q.push_word),
        .in_ready_o(buf_in_ready),
        .out_valid_o(word_valid_o),
        .out_word_o(word_o),
        .out_ready_i(word_ready_i)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign srom_clk_o = r_q.srom_clk;
    assign core_reset_o = r_q.core_rst;
    assign selftest_busy_o = r_q.selftest_busy;
    assign selftest_mark_o = r_q.first_event;
    assign load_busy_o = r_q.load_busy;
    assign clk_mode_o = r_q.mode_out;

endmodule

// ### hdl/sbs_skid_buf.sv
// Two-entry buffer for loaded words, valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sbs_skid_buf (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    input wire sbs_pkg::sbs_word_type in_word_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output sbs_pkg::sbs_word_type out_word_o,
    input wire logic out_ready_i
);

    sbs_pkg::sbs_buf_type r_q;
    sbs_pkg::sbs_buf_type r_d;

    // ------------------------------------------------------------
    // Head and tail update
    // ------------------------------------------------------------
    always_comb begin
        logic pop;
        logic push;
        pop = r_q.head_v & out_ready_i;
        push = in_valid_i & ~r_q.tail_v;
        r_d = r_q;
        if (pop) begin
            r_d.head = r_q.tail;
            r_d.head_v = r_q.tail_v;
            r_d.tail_v = 1'b0;
        end
        if (push) begin
            if (!r_d.head_v) begin
                r_d.head = in_word_i;
                r_d.head_v = 1'b1;
            end else begin
                r_d.tail = in_word_i;
                r_d.tail_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign in_ready_o = ~r_q.tail_v;
    assign out_valid_o = r_q.head_v;
    assign out_word_o = r_q.head;

endmodule

// ### tb/sbs_seq_asserts.sv
// Port checks for the start-up sequencer.
// Assumes a bind to sbs_seq; one clock, rst_i synchronous.
`timescale 1ns/1ps
module sbs_seq_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Board pins
    input wire logic sys_reset_n_i,
    input wire logic sys_clk_i,
    input wire logic [1:0] clk_mode_i,
    input wire logic [3:0] clk_ratio_i,
    input wire logic srom_present_n_i,
    // Serial ROM and words
    input wire logic srom_clk_o,
    input wire logic srom_data_i,
    input wire logic word_valid_o,
    input wire sbs_pkg::sbs_word_type word_o,
    input wire logic word_ready_i,
    // Status
    input wire logic core_reset_o,
    input wire logic selftest_busy_o,
    input wire logic selftest_mark_o,
    input wire logic load_busy_o,
    input wire sbs_pkg::sbs_clkmode_type clk_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Serial clock half-period counter
    // ------------------------------------------------------------
    logic prev_q;
    logic [7:0] half_q;
    always_ff @(posedge clk_i) begin
        prev_q <= srom_clk_o;
        if (rst_i || srom_clk_o != prev_q)
            half_q <= 8'h00;
        else if (half_q != 8'hFF)
            half_q <= half_q + 8'h01;
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_START: assert property ($rose(sys_reset_n_i) ##1
        sys_reset_n_i [*3] |-> ##[0:2] selftest_busy_o) else $error("no test");
    AST_NO_ROM_RUN: assert property (sys_reset_n_i [*6] ##0
        ($fell(selftest_busy_o) && srom_present_n_i) |-> ##[0:1] !core_reset_o)
        else $error("core reset held");
    AST_ROM_LOAD: assert property (sys_reset_n_i [*6] ##0
        ($fell(selftest_busy_o) && !srom_present_n_i) |-> ##[0:1] load_busy_o)
        else $error("load missing");
    AST_CORE_LOAD: assert property (load_busy_o |-> core_reset_o)
        else $error("core reset low in load");
    AST_ROM_HALF: assert property ((srom_clk_o != prev_q) && load_busy_o
        |-> half_q >= 8'h3E) else $error("serial clock too fast");
    AST_ROM_IDLE: assert property (!load_busy_o && !$past(load_busy_o)
        |-> !srom_clk_o) else $error("serial clock outside load");
    AST_MODE_GEN: assert property ((!rst_i && $stable(clk_mode_i)) [*5]
        |-> clk_mode_o.gen_reset == clk_mode_i[1]
        && clk_mode_o.normal_mode == !clk_mode_i[1]) else $error("mode bad");
    AST_MODE_EQ: assert property ((!rst_i && $stable(clk_mode_i)) [*5]
        |-> clk_mode_o.duty_eq_en == clk_mode_i[0]) else $error("eq bad");
    AST_MARK: assert property (selftest_mark_o |-> selftest_busy_o
        ##1 !selftest_mark_o) else $error("mark bad");
    cover property ($fell(selftest_busy_o) && load_busy_o);
    cover property (selftest_mark_o);
    cover property ($rose(srom_clk_o) && word_valid_o && !word_ready_i);
endmodule

bind sbs_seq sbs_seq_asserts u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sys_reset_n_i(sys_reset_n_i),
    .sys_clk_i(sys_clk_i),
    .clk_mode_i(clk_mode_i),
    .clk_ratio_i(clk_ratio_i),
    .srom_present_n_i(srom_present_n_i),
    .srom_clk_o(srom_clk_o),
    .srom_data_i(srom_data_i),
    .word_valid_o(word_valid_o),
    .word_o(word_o),
    .word_ready_i(word_ready_i),
    .core_reset_o(core_reset_o),
    .selftest_busy_o(selftest_busy_o),
    .selftest_mark_o(selftest_mark_o),
    .load_busy_o(load_busy_o),
    .clk_mode_o(clk_mode_o)
);

// ### tb/sbs_srom_model.sv
// Serial boot ROM model: serves a byte pattern, LSB first.
// Assumes the sequencer samples data on the serial clock rise.
`timescale 1ns/1ps
module sbs_srom_model (
    // Board reset
    input wire logic rst_n_i,
    // Serial link
    input wire logic srom_clk_i,
    output logic srom_data_o
);
    int bit_n = 0;
    function automatic logic [7:0] rom_byte(input int n);
        return 8'(n * 29 + 90);
    endfunction
    always @(posedge srom_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            bit_n = 0;
        else
            bit_n = bit_n + 1;
    end
    wire logic [7:0] cur = rom_byte(bit_n / 8);
    assign #20 srom_data_o = cur[bit_n % 8];
endmodule

// ### tb/tb.sv
// Self-checking bench of the start-up sequencer.
// Assumes sbs_seq, the ROM model and the bound checker.
`timescale 1ns/1ps
module tb;
    localparam int N4 = 20;
    localparam int N15 = 12;
    localparam int M4 = 300;
    localparam int M15 = 320;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sys_reset_n_i = 1'b0;
    logic sys_clk_i = 1'b0;
    logic [1:0] clk_mode_i = 2'h1;
    logic [3:0] clk_ratio_i = 4'h4;
    logic srom_present_n_i = 1'b1;
    logic word_ready_i = 1'b0;
    logic srom_clk_o, srom_data_i, word_valid_o;
    logic core_reset_o, selftest_busy_o, selftest_mark_o, load_busy_o;
    sbs_pkg::sbs_word_type word_o;
    sbs_pkg::sbs_clkmode_type clk_mode_o;
    int error_cnt = 0, checked = 0, st_n, ld_n, mark_at, rises, cyc = 0;
    int rise_c[2];
    sbs_seq #(.BUILT_IN_SELF_TEST_SYS_R4(N4), .BUILT_IN_SELF_TEST_SYS_R15(N15), .LOAD_SYS_R4(M4),
        .LOAD_SYS_R15(M15)) DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sys_reset_n_i(sys_reset_n_i),
        .sys_clk_i(sys_clk_i),
        .clk_mode_i(clk_mode_i),
        .clk_ratio_i(clk_ratio_i),
        .srom_present_n_i(srom_present_n_i),
        .srom_clk_o(srom_clk_o),
        .srom_data_i(srom_data_i),
        .word_valid_o(word_valid_o),
        .word_o(word_o),
        .word_ready_i(word_ready_i),
        .core_reset_o(core_reset_o),
        .selftest_busy_o(selftest_busy_o),
        .selftest_mark_o(selftest_mark_o),
        .load_busy_o(load_busy_o),
        .clk_mode_o(clk_mode_o)
    );
    sbs_srom_model u_rom (.rst_n_i(sys_reset_n_i), .srom_clk_i(srom_clk_o),
        .srom_data_o(srom_data_i));
    initial forever #5 clk_i = ~clk_i;
    // System clock pin, 160 ns period, driven on the CPU clock edge
    logic [2:0] sys_div = 3'h0;
    always @(posedge clk_i) begin
        sys_div <= sys_div + 3'h1;
        if (sys_div == 3'h7) begin
            sys_clk_i <= ~sys_clk_i;
            if (!sys_clk_i && selftest_busy_o) st_n++;
            if (!sys_clk_i && load_busy_o) ld_n++;
        end
    end
    always @(posedge clk_i) cyc++;
    always @(negedge clk_i) if (selftest_mark_o) mark_at = st_n;
    always @(posedge srom_clk_o) begin
        if (rises < 2) rise_c[rises] = cyc;
        rises++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_sig(input int sel, input logic lvl);
        logic s;
        for (int c = 0; c < 20000; c++) begin
            @(posedge clk_i);
            #1;
            s = sel == 0 ? selftest_busy_o : srom_clk_o;
            if (s === lvl) return;
        end
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic start_seq(input logic [3:0] ratio, input logic pres_n);
        @(posedge clk_i);
        sys_reset_n_i <= 1'b0;
        rst_i <= 1'b1;
        clk_ratio_i <= ratio;
        srom_present_n_i <= pres_n;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(posedge sys_clk_i);
        @(posedge clk_i);
        sys_reset_n_i <= 1'b1;
        st_n = 0;
        ld_n = 0;
        rises = 0;
        mark_at = -1;
        wait_sig(0, 1'b1);
        check("core_reset_o", 32'(core_reset_o), 1);
        wait_sig(0, 1'b0);
        check("test_len", st_n, ratio == 4'hF ? N15 : N4);
        check("mark_at", mark_at, 7);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_modes();
        sbs_pkg::sbs_clkmode_type e;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            clk_mode_i <= 2'(m);
            repeat (5) @(posedge clk_i);
            #1;
            e = '{gen_reset: m[1], duty_eq_en: m[0], normal_mode: !m[1]};
            check("clk_mode_o", 32'(clk_mode_o), 32'(e));
        end
        @(posedge clk_i);
        clk_mode_i <= 2'h1;
    endtask
    task automatic t_abort();
        start_seq(4'h6, 1'b0);
        wait_sig(1, 1'b1);
        @(posedge clk_i);
        sys_reset_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        check("core_reset_o", 32'(core_reset_o), 1);
        check("srom_clk_o", 32'(srom_clk_o), 0);
        check("load_busy_o", 32'(load_busy_o), 0);
    endtask
    task automatic t_no_rom();
        start_seq(4'h4, 1'b1);
        repeat (2) @(posedge clk_i);
        #1;
        check("core_reset_o", 32'(core_reset_o), 0);
        check("rom_rises", rises, 0);
    endtask
    task automatic t_load(input logic [3:0] ratio, input int hold,
        input int nmin);
        int k;
        logic v;
        sbs_pkg::sbs_word_type w;
        k = 0;
        start_seq(ratio, 1'b0);
        check("load_busy_o", 32'(load_busy_o), 1);
        for (int c = 0; c < 30000 && load_busy_o === 1'b1; c++) begin
            v = word_valid_o && word_ready_i;
            w = word_o;
            @(posedge clk_i);
            word_ready_i <= (c >= hold);
            #1;
            if (v) begin
                check("word_o", 32'(w.data), 32'(u_rom.rom_byte(k)));
                k++;
            end
        end
        if (load_busy_o !== 1'b0) begin
            error_cnt++;
            tally_and_finish();
        end
        repeat (2) @(posedge clk_i);
        #1;
        check("load_len", ld_n, ratio == 4'hF ? M15 : M4);
        check("words", 32'(k >= nmin), 1);
        check("core_reset_o", 32'(core_reset_o), 0);
        check("srom_clk_o", 32'(srom_clk_o), 0);
        check("bit_period", rise_c[1] - rise_c[0], 126);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_modes();
        t_abort();
        t_no_rom();
        t_load(4'h4, 0, 4);
        t_load(4'hF, 3600, 3);
        tally_and_finish();
    end
endmodule
